// *** dpf_pkg.sv ***
package dpf_pkg;

    // ------------------------------------------------------------------
    // sample format and arithmetic
    // ------------------------------------------------------------------
    localparam int            SMP_W     = 16;
    localparam int            COEF_W    = 16;
    localparam int            ACC_W     = 40;
    localparam int            COEF_FRAC = 15;
    localparam int            NCH       = 2;
    localparam int            NPATH     = 3;
    localparam int            NCOEF     = 13;
    localparam logic [15:0]   SAT_MAX   = 16'h7FFF;
    localparam logic [15:0]   SAT_MIN   = 16'h8000;

    // ------------------------------------------------------------------
    // timing: clock period and highest input sample rate
    // ------------------------------------------------------------------
    localparam int            CLK_PERIOD_NS     = 5;
    localparam int            MIN_FS_HZ         = 8000;
    localparam int            MAX_FS_HZ         = 96000;
    localparam int            SAMPLE_MIN_CYCLES = 1000000000 / (CLK_PERIOD_NS * MAX_FS_HZ);
    localparam int            PIPE_CYCLES       = 2;

    // ------------------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0]    ADDR_CTRL   = 8'h00;
    localparam logic [7:0]    ADDR_STATUS = 8'h01;
    localparam logic [7:0]    ADDR_ATTEN  = 8'h02;
    localparam logic [2:0]    COEF_PAGE   = 3'h1;
    localparam int            CTRL_DEEMPH = 0;
    localparam int            CTRL_EFFECT = 1;
    localparam int            CTRL_3D     = 2;
    localparam int            STAT_BUSY   = 3;

    // coefficient slots within one channel
    localparam int            K_DE_N0 = 0;
    localparam int            K_DE_N1 = 1;
    localparam int            K_DE_D1 = 2;
    localparam int            K_BQ1   = 3;
    localparam int            K_BQ2   = 8;

    // path state slots
    localparam int            S_DX1 = 0;
    localparam int            S_DY1 = 1;
    localparam int            S_A   = 2;
    localparam int            S_B   = 6;

    // reset coefficients, slot 12 first: de-emphasis 48 kHz set plus
    // two identical low-frequency shelving biquads (n0 n1 n2 d1 d2)
    localparam logic [NCOEF-1:0][15:0] COEF_DEF = {
        16'h84EE, 16'h7D83, 16'h675D, 16'h9666, 16'h6BE3,
        16'h84EE, 16'h7D83, 16'h675D, 16'h9666, 16'h6BE3,
        16'h537E, 16'hF32D, 16'h3955};

    localparam logic [7:0]    ATTEN_DEF = 8'h80;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [SMP_W-1:0] left;
        logic [SMP_W-1:0] right;
    } dpf_stereo_t;

    typedef logic [4:0][COEF_W-1:0]       dpf_bq_coef_t;
    typedef logic [NCOEF-1:0][COEF_W-1:0] dpf_chan_coef_t;
    typedef logic [9:0][SMP_W-1:0]        dpf_path_t;

    typedef struct packed {
        logic       hit;
        logic       ch;
        logic [3:0] k;
    } dpf_coef_sel_t;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_MUTE   = 3'b010,
        ST_SWITCH = 3'b100
    } dpf_state_t;

    // ------------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------------
    function automatic logic signed [ACC_W-1:0] mul(input logic [15:0] a, input logic [15:0] b);
        logic signed [ACC_W-1:0] ea;
        logic signed [ACC_W-1:0] eb;
        ea  = ACC_W'($signed(a));
        eb  = ACC_W'($signed(b));
        mul = ea * eb;
    endfunction

    function automatic logic [15:0] sat16(input logic signed [ACC_W-1:0] v);
        if (v > ACC_W'($signed(SAT_MAX)))
            sat16 = SAT_MAX;
        else if (v < ACC_W'($signed(SAT_MIN)))
            sat16 = SAT_MIN;
        else
            sat16 = v[15:0];
    endfunction

    function automatic logic [15:0] deemph(input logic [15:0] x, input logic [15:0] x1,
                                           input logic [15:0] y1, input logic [15:0] n0,
                                           input logic [15:0] n1, input logic [15:0] d1);
        logic signed [ACC_W-1:0] acc;
        acc    = mul(n0, x) + mul(n1, x1) + mul(d1, y1);
        deemph = sat16(acc >>> COEF_FRAC);
    endfunction

    // c: n0 n1 n2 d1 d2 at slots 0..4; middle taps carry the factor two
    function automatic logic [15:0] biquad(input logic [15:0] x, input logic [15:0] x1,
                                           input logic [15:0] x2, input logic [15:0] y1,
                                           input logic [15:0] y2, input dpf_bq_coef_t c);
        logic signed [ACC_W-1:0] acc;
        acc    = mul(c[0], x) + (mul(c[1], x1) <<< 1) + mul(c[2], x2)
               + (mul(c[3], y1) <<< 1) + mul(c[4], y2);
        biquad = sat16(acc >>> COEF_FRAC);
    endfunction

    function automatic dpf_coef_sel_t coef_sel(input logic [7:0] addr);
        coef_sel.ch  = addr[4];
        coef_sel.k   = addr[3:0];
        coef_sel.hit = (addr[7:5] == COEF_PAGE) && (32'(addr[3:0]) < NCOEF);
    endfunction

endpackage

// *** dpf_top.sv ***
module dpf_top
    import dpf_pkg::*;
#(
    parameter int ATTEN_W = 8
)(
    input  wire logic        clock_i,      // 200 MHz core clock
    input  wire logic        resetn_i,     // async reset, active low
    input  wire logic        ce_i,         // clock enable, freezes all state
    input  wire logic [7:0]  reg_addr_i,   // register word address
    input  wire logic [15:0] reg_wdata_i,  // register write data
    input  wire logic        reg_we_i,     // write strobe
    input  wire logic        reg_re_i,     // read strobe
    output      logic [15:0] reg_rdata_o,  // read data, cycle after strobe
    input  wire logic        in_valid_i,   // one pulse per input sample
    input  wire dpf_stereo_t in_sample_i,  // stereo input sample
    output      logic        out_valid_o,  // one pulse per output sample
    output      dpf_stereo_t out_sample_o, // processed sample to interpolator
    output      logic        mute_req_o,   // request soft-mute of volume
    input  wire logic        muted_i       // volume has reached mute
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // rate headroom check
    if (SAMPLE_MIN_CYCLES < PIPE_CYCLES || MIN_FS_HZ > MAX_FS_HZ)
        $error("clock too slow for the highest sample rate");
    if (ATTEN_W < 1 || ATTEN_W > 15)
        $error("ATTEN_W must lie in 1..15");

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        dpf_state_t                 fsm;
        logic [2:0]                 ctrl;
        logic [2:0]                 act;
        logic [ATTEN_W-1:0]         atten;
        logic [NCH-1:0][NCOEF-1:0][COEF_W-1:0] coef;
        logic [NPATH-1:0][9:0][SMP_W-1:0]     path;
        logic [15:0]                rdata;
        logic                       out_v;
        dpf_stereo_t                out;
    } dpf_reg_t;

    localparam dpf_reg_t RST = '{
        fsm:   ST_RUN,
        ctrl:  3'h0,
        act:   3'h0,
        atten: ATTEN_W'(ATTEN_DEF),
        coef:  {NCH{COEF_DEF}},
        path:  '0,
        rdata: 16'h0000,
        out_v: 1'b0,
        out:   '0
    };

    dpf_reg_t      q;
    dpf_reg_t      d;
    dpf_coef_sel_t wsel;
    dpf_coef_sel_t rsel;

    logic [NPATH-1:0][15:0] x_in;
    logic [NPATH-1:0][15:0] de_y;
    logic [NPATH-1:0][15:0] a_y;
    logic [NPATH-1:0][15:0] b_y;
    logic [NPATH-1:0][0:0]  cch;
    logic [15:0]            mono;
    logic [15:0]            fx;
    logic [15:0]            add_l;
    logic [15:0]            add_r;
    logic                   apply;

    assign wsel = coef_sel(reg_addr_i);
    assign rsel = coef_sel(reg_addr_i);

    // ------------------------------------------------------------------
    // datapath: de-emphasis, two biquads, 3-D mix
    // ------------------------------------------------------------------
    always_comb
    begin
        x_in    = '0;
        de_y    = '0;
        a_y     = '0;
        b_y     = '0;
        cch     = '0;
        mono    = 16'h0000;
        fx      = 16'h0000;
        add_l   = 16'h0000;
        add_r   = 16'h0000;
        x_in[0] = in_sample_i.left;
        x_in[1] = in_sample_i.right;
        cch[1]  = 1'b1;
        for (int p = 0; p < NCH; p++)
        begin
            de_y[p] = deemph(x_in[p], q.path[p][S_DX1], q.path[p][S_DY1],
                             q.coef[p][K_DE_N0], q.coef[p][K_DE_N1], q.coef[p][K_DE_D1]);
            if (!q.act[CTRL_DEEMPH])
                de_y[p] = x_in[p];
        end
        mono    = sat16((ACC_W'($signed(de_y[0])) + ACC_W'($signed(de_y[1]))) >>> 1);
        x_in[2] = mono;
        de_y[2] = mono;
        for (int p = 0; p < NPATH; p++)
        begin
            a_y[p] = biquad(de_y[p], q.path[p][S_A], q.path[p][S_A+1],
                            q.path[p][S_A+2], q.path[p][S_A+3],
                            q.coef[cch[p]][K_BQ1+4:K_BQ1]);
            b_y[p] = biquad(a_y[p], q.path[p][S_B], q.path[p][S_B+1],
                            q.path[p][S_B+2], q.path[p][S_B+3],
                            q.coef[cch[p]][K_BQ2+4:K_BQ2]);
        end
        fx    = sat16((mul(b_y[2], 16'(q.atten))) >>> ATTEN_W);
        add_l = sat16(ACC_W'($signed(de_y[0])) + ACC_W'($signed(fx)));
        add_r = sat16(ACC_W'($signed(de_y[1])) + ACC_W'($signed(fx)));
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d       = q;
        apply   = 1'b0;
        d.out_v = 1'b0;
        d.rdata = 16'h0000;

        // register writes
        if (reg_we_i)
        begin
            if (reg_addr_i == ADDR_CTRL)
                d.ctrl = reg_wdata_i[2:0];
            if (reg_addr_i == ADDR_ATTEN)
                d.atten = reg_wdata_i[ATTEN_W-1:0];
            if (wsel.hit)
                d.coef[wsel.ch][wsel.k] = reg_wdata_i;
        end

        // register reads, unmapped read as zero
        if (reg_re_i)
        begin
            if (reg_addr_i == ADDR_CTRL)
                d.rdata = {13'h0000, q.ctrl};
            else if (reg_addr_i == ADDR_STATUS)
                d.rdata = {12'h000, (q.fsm != ST_RUN), q.act};
            else if (reg_addr_i == ADDR_ATTEN)
                d.rdata = 16'(q.atten);
            else if (rsel.hit)
                d.rdata = q.coef[rsel.ch][rsel.k];
        end

        unique case (q.fsm)
            ST_RUN:
            begin
                if (q.ctrl != q.act)
                    d.fsm = ST_MUTE;
            end
            ST_MUTE:
            begin
                if (muted_i)
                    d.fsm = ST_SWITCH;
            end
            ST_SWITCH:
            begin
                // change only on a sample boundary
                if (in_valid_i)
                begin
                    apply = 1'b1;
                    d.fsm = ST_RUN;
                end
            end
            default:
                d.fsm = ST_RUN;
        endcase

        if (in_valid_i)
        begin
            d.out_v = 1'b1;
            for (int p = 0; p < NCH; p++)
            begin
                d.path[p][S_DX1] = x_in[p];
                d.path[p][S_DY1] = de_y[p];
            end
            for (int p = 0; p < NPATH; p++)
            begin
                d.path[p][S_A+1] = q.path[p][S_A];
                d.path[p][S_A]   = de_y[p];
                d.path[p][S_A+3] = q.path[p][S_A+2];
                d.path[p][S_A+2] = a_y[p];
                d.path[p][S_B+1] = q.path[p][S_B];
                d.path[p][S_B]   = a_y[p];
                d.path[p][S_B+3] = q.path[p][S_B+2];
                d.path[p][S_B+2] = b_y[p];
            end
            if (q.act[CTRL_3D])
            begin
                d.out.left  = add_l;
                d.out.right = add_r;
            end
            else if (q.act[CTRL_EFFECT])
            begin
                d.out.left  = b_y[0];
                d.out.right = b_y[1];
            end
            else
            begin
                d.out.left  = de_y[0];
                d.out.right = de_y[1];
            end
        end

        if (apply)
        begin
            d.act  = q.ctrl;
            d.path = '0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q <= RST;
        else if (ce_i)
            q <= d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o  = q.rdata;
    // processed sample goes to the interpolator
    // interpolator owns the fixed upsampled rate
    assign out_valid_o  = q.out_v;
    assign out_sample_o = q.out;
    assign mute_req_o   = (q.fsm != ST_RUN);

endmodule

// *** dpf_checker_properties.sv ***
module dpf_checker
    import dpf_pkg::*;
#(
    parameter int ATTEN_W = 8
)(
    input wire logic        clock_i,      // core clock
    input wire logic        resetn_i,     // reset, active low
    input wire logic        ce_i,         // clock enable
    input wire logic [7:0]  reg_addr_i,   // register address
    input wire logic [15:0] reg_wdata_i,  // write data
    input wire logic        reg_we_i,     // write strobe
    input wire logic        reg_re_i,     // read strobe
    input wire logic [15:0] reg_rdata_o,  // read data
    input wire logic        in_valid_i,   // input strobe
    input wire dpf_stereo_t in_sample_i,  // input sample
    input wire logic        out_valid_o,  // output strobe
    input wire dpf_stereo_t out_sample_o, // output sample
    input wire logic        mute_req_o,   // mute request
    input wire logic        muted_i       // volume at mute
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // output per input
    AST_OUT_FOLLOWS: assert property (in_valid_i && ce_i |=> out_valid_o)
        else $error("no output after input sample");
    AST_NO_SPURIOUS: assert property (out_valid_o |-> $past(in_valid_i) && $past(ce_i))
        else $error("output without input sample");
    AST_OUT_STABLE: assert property (!out_valid_o |-> $stable(out_sample_o))
        else $error("output sample changed between outputs");
    AST_RDATA_IDLE: assert property (ce_i && !reg_re_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside read");
    // mute two edges after control write
    AST_MUTE_CAUSE: assert property ($rose(mute_req_o) |-> $past(reg_we_i, 2) && $past(reg_addr_i, 2) == ADDR_CTRL)
        else $error("mute request without control write");
    AST_MUTE_HOLD: assert property (mute_req_o && !(in_valid_i && ce_i) |=> mute_req_o)
        else $error("mute request dropped without sample");
    AST_FALL_ON_SAMPLE: assert property ($fell(mute_req_o) |-> out_valid_o && $past(in_valid_i))
        else $error("unmute not on sample boundary");
    AST_FALL_NEEDS_MUTED: assert property ($fell(mute_req_o) |-> $past(muted_i))
        else $error("filtering switched before volume muted");
    cover property ($fell(mute_req_o));
    cover property (reg_re_i ##1 reg_rdata_o != 16'h0000);
    cover property (in_valid_i ##1 out_valid_o);
endmodule

bind dpf_top dpf_checker #(.ATTEN_W(ATTEN_W)) dpf_checker_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i), .in_sample_i(in_sample_i),
    .out_valid_o(out_valid_o), .out_sample_o(out_sample_o), .mute_req_o(mute_req_o),
    .muted_i(muted_i));

// *** dpf_vol_model.sv ***
module dpf_vol_model (
    input  wire logic       clock_i,    // core clock
    input  wire logic       resetn_i,   // reset, active low
    input  wire logic       mute_req_i, // ramp request
    input  wire logic [3:0] lag_i,      // ramp length in cycles
    output      logic       muted_o     // volume at mute
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_q   <= 4'h0;
            muted_o <= 1'b0;
        end
        else if (!mute_req_i)
        begin
            cnt_q   <= 4'h0;
            muted_o <= 1'b0;
        end
        else if (cnt_q >= lag_i)
            muted_o <= 1'b1;
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dpf_pkg::*;
    logic        clock_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, muted_i, mute_req_o;
    logic        reg_we_i = 1'b0, reg_re_i = 1'b0, in_valid_i = 1'b0, out_valid_o;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic [3:0]  lag = 4'h0;
    logic [2:0]  mode = 3'h0;
    logic [31:0] rnd = 32'h85058215;
    dpf_stereo_t in_sample_i = '0, out_sample_o;
    int          fails = 0, n_tests = 0, cyc = 0;
    logic signed [15:0] cf [2][13];
    logic signed [15:0] st [3][10];
    logic signed [15:0] dv [2];
    logic [7:0]  atten = ATTEN_DEF;
    localparam logic [15:0] DEF [13] = '{16'h3955, 16'hF32D, 16'h537E, 16'h6BE3, 16'h9666,
        16'h675D, 16'h7D83, 16'h84EE, 16'h6BE3, 16'h9666, 16'h675D, 16'h7D83, 16'h84EE};

    dpf_top dpf_top_i (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
        .in_sample_i(in_sample_i), .out_valid_o(out_valid_o), .out_sample_o(out_sample_o),
        .mute_req_o(mute_req_o), .muted_i(muted_i));
    dpf_vol_model dpf_vol_model_i (.clock_i(clock_i), .resetn_i(resetn_i),
        .mute_req_i(mute_req_o), .lag_i(lag), .muted_o(muted_i));

    always #2.5 clock_i = ~clock_i;

    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic longint m(input logic signed [15:0] a, input logic signed [15:0] b);
        return longint'(a) * longint'(b);
    endfunction
    function automatic logic signed [15:0] sat(input longint v);
        return (v > 64'sh7FFF) ? 16'h7FFF : (v < -64'sh8000) ? 16'h8000 : v[15:0];
    endfunction
    // c: state path, g: coefficient channel, s: first state slot, k: first coefficient slot
    function automatic logic signed [15:0] bq(input int c, input int g, input int s, input int k,
                                              input logic signed [15:0] x);
        logic signed [15:0] y;
        y = sat((m(cf[g][k], x) + (m(cf[g][k+1], st[c][s]) <<< 1) + m(cf[g][k+2], st[c][s+1])
            + (m(cf[g][k+3], st[c][s+2]) <<< 1) + m(cf[g][k+4], st[c][s+3])) >>> 15);
        st[c][s+1] = st[c][s];
        st[c][s] = x;
        st[c][s+3] = st[c][s+2];
        st[c][s+2] = y;
        return y;
    endfunction
    function automatic logic [15:0] step(input int c, input logic signed [15:0] x);
        logic signed [15:0] d, v, b;
        d = sat((m(cf[c][0], x) + m(cf[c][1], st[c][0]) + m(cf[c][2], st[c][1])) >>> 15);
        st[c][0] = x;
        st[c][1] = d;
        v = mode[0] ? d : x;
        dv[c] = v;
        b = bq(c, c, 6, 8, bq(c, c, 2, 3, v));
        return mode[1] ? b : v;
    endfunction

    // ----------------------------------------------------------------
    // bus and stream tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock_i);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_re_i <= 1'b0;
        #1 chk("reg_rdata_o", {16'h0000, e}, {16'h0000, reg_rdata_o});
    endtask
    task automatic send(input dpf_stereo_t s);
        dpf_stereo_t e;
        logic signed [15:0] fx;
        e.left  = step(0, s.left);
        e.right = step(1, s.right);
        // mono mix through left sections, scaled
        fx = bq(2, 0, 6, 8, bq(2, 0, 2, 3, sat((longint'(dv[0]) + longint'(dv[1])) >>> 1)));
        fx = sat(m(fx, {8'h00, atten}) >>> $bits(atten));
        if (mode[2])
        begin
            e.left  = sat(longint'(dv[0]) + longint'(fx));
            e.right = sat(longint'(dv[1]) + longint'(fx));
        end
        @(posedge clock_i);
        in_valid_i  <= 1'b1;
        in_sample_i <= s;
        @(posedge clock_i);
        in_valid_i <= 1'b0;
        #1 chk("out_valid_o", 32'h1, {31'h0, out_valid_o});
        chk("out_sample_o", e, out_sample_o);
    endtask
    task automatic burst(input int n);
        for (int i = 0; i < n; i++)
        begin
            rnd = lfsr(rnd);
            send(rnd);
        end
    endtask
    task automatic set_mode(input logic [2:0] mn);
        rnd = lfsr(rnd);
        lag <= rnd[3:0];
        wr(ADDR_CTRL, {13'h0000, mn});
        @(posedge clock_i);
        #1 chk("mute_req_o", 32'h1, {31'h0, mute_req_o});
        for (int i = 0; i < 40 && muted_i !== 1'b1; i++) @(posedge clock_i);
        burst(1);
        chk("mute_req_o", 32'h0, {31'h0, mute_req_o});
        st   = '{default: 16'h0000};
        mode = mn;
        rd(ADDR_STATUS, {13'h0000, mn});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict;
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        st = '{default: 16'h0000};
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 13; k++)
            begin
                cf[c][k] = DEF[k];
                rd({3'h1, c[0], k[3:0]}, DEF[k]);
            end
        rd(8'h2D, 16'h0000);
        rd(ADDR_ATTEN, {8'h00, ATTEN_DEF});
        send(32'h7FFF8000);
        burst(10);
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 3; k++)
            begin
                rnd = lfsr(rnd);
                cf[c][k] = rnd[15:0];
                wr({3'h1, c[0], k[3:0]}, rnd[15:0]);
                rd({3'h1, c[0], k[3:0]}, rnd[15:0]);
            end
        set_mode(3'h1);
        send(32'h7FFF7FFF);
        send(32'h80008000);
        burst(20);
        set_mode(3'h0);
        for (int c = 0; c < 2; c++)
        begin
            cf[c][8] = 16'h2000;
            wr({3'h1, c[0], 4'h8}, 16'h2000);
        end
        set_mode(3'h3);
        burst(20);
        set_mode(3'h2);
        burst(10);
        rnd   = lfsr(rnd);
        atten = rnd[7:0];
        wr(ADDR_ATTEN, {8'h00, atten});
        rd(ADDR_ATTEN, {8'h00, atten});
        // ce low freezes writes and samples
        @(posedge clock_i);
        ce_i        <= 1'b0;
        reg_we_i    <= 1'b1;
        reg_wdata_i <= {8'h00, ~atten};
        in_valid_i  <= 1'b1;
        repeat (3) @(posedge clock_i);
        ce_i       <= 1'b1;
        reg_we_i   <= 1'b0;
        in_valid_i <= 1'b0;
        #1 chk("out_valid_o", 32'h0, {31'h0, out_valid_o});
        rd(ADDR_ATTEN, {8'h00, atten});
        set_mode(3'h7);
        burst(20);
        give_verdict;
    end
endmodule
